// *** sim/lcd_host_command_port_tb.sv ***
// bench joining host end and device end over the command port
`timescale 1ns/1ps
module lcd_host_command_port_tb;
  logic clk_in = 1'b0; // 250 mhz clock
  logic rst_n_in = 1'b0; // async reset, active low
  logic [3:0] address_in = 4'h0; // avalon byte address
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0;
  logic [31:0] readdata_out;
  logic waitrequest_out;
  logic mux_mode_in = 1'b0; // wiring strap
  logic [7:0] read_data_in = 8'h3c; // byte served to data reads
  logic cmd_valid_out, cmd_c1_out, cmd_c2_out, cmd_rw_out, busy_out, nibble_mode_out;
  logic [7:0] cmd_code_out;
  logic [31:0] rd; // last register read
  logic [10:0] last_cmd = 11'h0; // last executed {c1, c2, rw, code}
  int n_exec = 0; // executed commands seen
  int e; // execution count before a step
  int err_count = 0;
  int checks = 0;
  always #2 clk_in = ~clk_in;
  lcd_port_if port_if ();
  lcd_port_host u_lcd_port_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .port_io(port_if),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out));
  // short autoclear keeps the run brief
  lcd_port_device #(.AUTOCLEAR_CYC(20)) u_lcd_port_device (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .port_io(port_if), .mux_mode_in(mux_mode_in),
    .read_data_in(read_data_in), .cmd_valid_out(cmd_valid_out), .cmd_c1_out(cmd_c1_out),
    .cmd_c2_out(cmd_c2_out), .cmd_rw_out(cmd_rw_out), .cmd_code_out(cmd_code_out),
    .busy_out(busy_out), .nibble_mode_out(nibble_mode_out));
  lcd_port_asserts u_lcd_port_asserts (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .execute_strobe(port_if.execute_strobe), .read_write_select(port_if.read_write_select),
    .host_bus_oe(port_if.host_bus_oe), .dev_bus_oe(port_if.dev_bus_oe),
    .mux_mode_in(mux_mode_in), .cmd_valid_out(cmd_valid_out), .cmd_c1_out(cmd_c1_out),
    .cmd_c2_out(cmd_c2_out), .cmd_rw_out(cmd_rw_out), .cmd_code_out(cmd_code_out),
    .busy_out(busy_out), .nibble_mode_out(nibble_mode_out));
  // record each execute pulse
  always @(posedge clk_in) begin
    if (cmd_valid_out === 1'b1) begin
      n_exec++;
      last_cmd = {cmd_c1_out, cmd_c2_out, cmd_rw_out, cmd_code_out};
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic timeout();
    err_count++;
    wrap_up();
  endtask : timeout
  // one avalon access, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address_in <= a;
    writedata_in <= d;
    write_in <= wr;
    read_in <= ~wr;
    @(posedge clk_in);
    while (waitrequest_out !== 1'b0 && n < 60000) begin
      @(posedge clk_in);
      n++;
    end
    rd = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
    @(posedge clk_in);
    if (n >= 60000) timeout();
  endtask : av
  // launch a command and read status until the engine is idle
  task automatic cmd(input logic [2:0] crw, input logic [7:0] code);
    int n;
    n = 0;
    av(1'b1, lcd_port_pkg::REG_CMD, {21'h0, crw, code});
    do begin
      av(1'b0, lcd_port_pkg::REG_STAT, 32'h0);
      n++;
    end while (rd[lcd_port_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 3000);
    if (n >= 3000) timeout();
  endtask : cmd
  // wait for the device busy flag to fall
  task automatic busy_low();
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 2000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 2000) timeout();
  endtask : busy_low
  // reset both ends with the given wiring strap
  task automatic do_reset(input logic mux);
    rst_n_in <= 1'b0;
    mux_mode_in <= mux;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    check(busy_out, 32'h1);
    check(nibble_mode_out, 32'h0);
    busy_low();
  endtask : do_reset
  // status byte from the last poll, busy and nibble bits only
  function automatic logic [31:0] stat_flags();
    return {24'h0, rd[15:8] & 8'hc0};
  endfunction : stat_flags
  initial begin
    do_reset(1'b0);
    av(1'b0, lcd_port_pkg::REG_MODE, 32'h0);
    check(rd, 32'h0);
    av(1'b1, 4'hc, 32'hffff_ffff);
    av(1'b0, 4'hc, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
    cmd(3'b100, 8'h5a);
    check(last_cmd, {3'b100, 8'h5a});
    check(busy_out, 32'h1);
    e = n_exec;
    cmd(3'b010, 8'h81);
    check(n_exec, e + 1);
    check(last_cmd, {3'b010, 8'h81});
    cmd(3'b011, 8'h00);
    av(1'b0, lcd_port_pkg::REG_STAT, 32'h0);
    check(rd[15:8], 32'h3c);
    $display("test port8 done");
    busy_low();
    e = n_exec;
    cmd(3'b000, 8'h00);
    check(n_exec, e);
    cmd(3'b001, 8'h00);
    av(1'b0, lcd_port_pkg::REG_STAT, 32'h0);
    check(stat_flags(), 32'h80);
    busy_low();
    cmd(3'b001, 8'h00);
    av(1'b0, lcd_port_pkg::REG_STAT, 32'h0);
    check(stat_flags(), 32'h00);
    $display("test nop_poll done");
    e = n_exec;
    cmd(3'b000, 8'hc0);
    check(nibble_mode_out, 32'h1);
    check(n_exec, e + 1);
    av(1'b0, lcd_port_pkg::REG_MODE, 32'h0);
    check(rd[1], 32'h1);
    e = n_exec;
    cmd(3'b100, 8'h96);
    check(n_exec, e + 1);
    check(last_cmd, {3'b100, 8'h96});
    cmd(3'b001, 8'h00);
    av(1'b0, lcd_port_pkg::REG_STAT, 32'h0);
    check(stat_flags(), 32'hc0);
    read_data_in <= 8'ha7;
    cmd(3'b011, 8'h00);
    av(1'b0, lcd_port_pkg::REG_STAT, 32'h0);
    check(rd[15:8], 32'ha7);
    cmd(3'b000, 8'he0);
    check(nibble_mode_out, 32'h0);
    $display("test nibble done");
    do_reset(1'b1);
    av(1'b1, lcd_port_pkg::REG_MODE, 32'h1);
    cmd(3'b110, 8'h3c);
    check(last_cmd, {3'b110, 8'h3c});
    read_data_in <= 8'h5e;
    cmd(3'b011, 8'h00);
    av(1'b0, lcd_port_pkg::REG_STAT, 32'h0);
    check(rd[15:8], 32'h5e);
    cmd(3'b000, 8'hc0);
    check(nibble_mode_out, 32'h0);
    cmd(3'b010, 8'hf0);
    check(last_cmd, {3'b010, 8'hf0});
    $display("test muxed done");
    wrap_up();
  end
endmodule : lcd_host_command_port_tb

// *** sim/lcd_port_asserts.sv ***
// concurrent checks on the port wires and the device flags
`timescale 1ns/1ps
module lcd_port_asserts (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic execute_strobe,
  input wire logic read_write_select,
  input wire logic host_bus_oe,
  input wire logic dev_bus_oe,
  input wire logic mux_mode_in,
  input wire logic cmd_valid_out,
  input wire logic cmd_c1_out,
  input wire logic cmd_c2_out,
  input wire logic cmd_rw_out,
  input wire logic [7:0] cmd_code_out,
  input wire logic busy_out,
  input wire logic nibble_mode_out
);
  localparam int EXEC_MAX = 1010; // busy span plus a little slack
  logic [11:0] busy_run_q; // consecutive cycles with busy high
  int unsigned gap_q; // cycles since the last non-poll execution
  logic seen_q; // a non-poll execution has happened
  logic exec_np; // executed command is not a busy poll
  assign exec_np = cmd_valid_out & (~cmd_rw_out | cmd_c1_out | cmd_c2_out);
  // gap counter saturates so it never wraps back to a small value
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_q <= 0;
      seen_q <= 1'b0;
    end else if (exec_np) begin
      gap_q <= 0;
      seen_q <= 1'b1;
    end else if (gap_q < 5000) begin
      gap_q <= gap_q + 1;
    end
  end
  // busy run length, saturating; a delay range this long would be too slow to unroll
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_run_q <= 12'h000;
    end else if (!busy_out) begin
      busy_run_q <= 12'h000; // flag dropped: run over
    end else if (busy_run_q != 12'hfff) begin
      busy_run_q <= busy_run_q + 12'h001;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_reset_busy: assert property (!$past(rst_n_in) |-> busy_out)
    else $error("busy flag low right after reset");
  chk_reset_port: assert property (!$past(rst_n_in) |-> !nibble_mode_out)
    else $error("nibble mode set right after reset");
  chk_nop_silent: assert property (cmd_valid_out |->
    !(cmd_code_out == 8'h00 && !cmd_c1_out && !cmd_c2_out && !cmd_rw_out))
    else $error("no-op produced an execute pulse");
  chk_exec_busy: assert property (exec_np |-> ##[0:4] busy_out)
    else $error("busy not raised by executed command");
  chk_busy_bound: assert property (busy_run_q <= 12'(EXEC_MAX))
    else $error("busy flag never cleared");
  chk_busy_drop: assert property (exec_np && seen_q |-> gap_q >= 900)
    else $error("command executed while busy");
  chk_bus_conflict: assert property (!(host_bus_oe && dev_bus_oe))
    else $error("both ends drive the data lines");
  // the device sees the read strobe through two sync stages, so it lets go up to three
  // cycles after the strobe is released
  chk_dev_drive: assert property (dev_bus_oe |->
    (mux_mode_in ? (!read_write_select || !$past(read_write_select, 3))
                 : read_write_select))
    else $error("device drives data outside a read");
  chk_mux_width: assert property (mux_mode_in |-> !nibble_mode_out)
    else $error("nibble mode entered on muxed bus");
  chk_strobe_hold: assert property ($rose(execute_strobe) |=> execute_strobe[*8])
    else $error("strobe phase too short");
endmodule : lcd_port_asserts

// *** verilog/lcd_port_device.sv ***
// device end: command port of the display controller
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps
module lcd_port_device #(
  parameter int AUTOCLEAR_CYC = lcd_port_pkg::AUTOCLEAR_CYC // power-up clear length
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  lcd_port_if.device_end port_io,
  input wire logic mux_mode_in, // strap: muxed-bus wiring
  input wire logic [7:0] read_data_in, // byte for data reads
  output logic cmd_valid_out, // one-cycle execute pulse
  output logic cmd_c1_out, // class bit 1 of executed command
  output logic cmd_c2_out, // class bit 2 of executed command
  output logic cmd_rw_out, // direction of executed command
  output logic [7:0] cmd_code_out, // code of executed command
  output logic busy_out, // busy flag
  output logic nibble_mode_out // nibble mode in force
);
  typedef struct packed {
    logic [3:0] s1; // pin sync, first stage
    logic [3:0] s2; // pin sync, second stage
    logic [3:0] s3; // previous second stage, for edges
    logic [7:0] d1; // data sync, first stage
    logic [7:0] d2; // data sync, second stage
    logic m1; // strap sync, first stage
    logic m2; // strap sync, second stage
    logic mux; // muxed-bus mode
    logic nib; // nibble mode
    logic phase; // next strobe is the lower nibble
    logic [3:0] hi_nib; // held upper nibble
    logic c1; // class bit 1 of the pending command
    logic c2; // class bit 2 of the pending command
    logic rw; // direction of the pending command
    logic sel; // chip selected by the muxed address
    logic busy; // busy flag
    logic booting; // power-up autoclear running
    logic [15:0] cnt; // busy countdown
    logic [7:0] dout; // read drive value
    logic doe; // read drive enable
    logic cv; // execute pulse
    logic [7:0] code; // executed code
  } dev_state_t;
  // reset value: busy through autoclear, 8-bit port mode
  localparam dev_state_t RST_STATE = '{
    busy: 1'b1,
    booting: 1'b1,
    cnt: 16'(AUTOCLEAR_CYC - 1),
    default: '0
  };
  dev_state_t q, d;
  logic stb_rise; // port strobe or address latch rising
  logic stb_fall; // port strobe or address latch falling
  logic rd_fall; // muxed read strobe asserted
  logic rd_rise; // muxed read strobe released
  logic wr_rise; // muxed write strobe released
  logic exec; // a command completes this cycle
  logic [7:0] ecode; // code of the completing command
  logic [7:0] status; // busy and function flags
  logic [7:0] full; // byte a read returns
  logic poll_now; // pending command is the busy poll
  // next state
  always_comb begin
    d = q;
    d.cv = 1'b0;
    exec = 1'b0;
    ecode = q.code;
    // two stages on every pin before any use
    d.s1 = {port_io.execute_strobe, port_io.instr_class_bit1,
            port_io.instr_class_bit2, port_io.read_write_select};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.d1 = port_io.host_data_bus;
    d.d2 = q.d1;
    d.m1 = mux_mode_in;
    d.m2 = q.m1;
    // edges from the second stage only
    stb_rise = q.s2[lcd_port_pkg::PIN_STB] & ~q.s3[lcd_port_pkg::PIN_STB];
    stb_fall = ~q.s2[lcd_port_pkg::PIN_STB] & q.s3[lcd_port_pkg::PIN_STB];
    rd_fall = ~q.s2[lcd_port_pkg::PIN_RW] & q.s3[lcd_port_pkg::PIN_RW];
    rd_rise = q.s2[lcd_port_pkg::PIN_RW] & ~q.s3[lcd_port_pkg::PIN_RW];
    wr_rise = q.s2[lcd_port_pkg::PIN_C1] & ~q.s3[lcd_port_pkg::PIN_C1];
    // the read byte: status for the poll, else user data
    status = 8'h00;
    status[lcd_port_pkg::BUSY_BIT] = q.busy;
    status[lcd_port_pkg::NIB_FLAG_BIT] = q.nib;
    // class and direction as they stand on the pins at the strobe in port mode, as latched from the address in muxed mode
    poll_now = lcd_port_pkg::is_poll(q.s2[lcd_port_pkg::PIN_C1],
                                     q.s2[lcd_port_pkg::PIN_C2],
                                     q.s2[lcd_port_pkg::PIN_RW]);
    if (q.mux) begin
      poll_now = lcd_port_pkg::is_poll(q.c1, q.c2, q.rw);
    end
    full = poll_now ? status : read_data_in;
    // busy countdown; mode strap followed only during autoclear
    if (q.busy) begin
      if (q.cnt == 16'h0) begin
        d.busy = 1'b0;
        d.booting = 1'b0;
      end else begin
        d.cnt = q.cnt - 16'h1;
      end
    end
    if (q.booting) begin
      d.mux = q.m2;
    end
    if (!q.mux) begin
      // port mode: pins are strobe, class bits and direction
      if (stb_rise) begin
        d.c1 = q.s2[lcd_port_pkg::PIN_C1];
        d.c2 = q.s2[lcd_port_pkg::PIN_C2];
        d.rw = q.s2[lcd_port_pkg::PIN_RW];
        if (q.s2[lcd_port_pkg::PIN_RW]) begin
          // drive the read byte while the strobe is high
          d.doe = 1'b1;
          if (!q.nib) begin
            d.dout = full;
          end else begin
            // nibbles return on the upper lines
            d.dout = {q.phase ? full[3:0] : full[7:4], 4'h0};
          end
        end
      end
      // the strobe's end executes what was presented
      if (stb_fall) begin
        d.doe = 1'b0;
        if (q.nib) begin
          d.phase = ~q.phase;
          if (!q.phase) begin
            // first half only held, no busy yet
            d.hi_nib = q.d2[7:4];
          end else begin
            exec = 1'b1;
            ecode = {q.hi_nib, q.d2[7:4]};
          end
        end else begin
          exec = 1'b1;
          ecode = q.d2;
        end
      end
    end else begin
      // muxed mode: pins are latch, strobes and io select
      if (stb_fall) begin
        // address decode: upper five bits ones, io cycle
        d.sel = q.s2[lcd_port_pkg::PIN_C2]
              & (q.d2[7:3] == lcd_port_pkg::IO_ADDR_HI);
        d.rw = q.d2[lcd_port_pkg::ADDR_RW_BIT];
        d.c1 = q.d2[lcd_port_pkg::ADDR_C1_BIT];
        d.c2 = q.d2[lcd_port_pkg::ADDR_C2_BIT];
      end
      if (rd_fall && q.sel) begin
        // data phase of a read
        d.doe = 1'b1;
        d.dout = full;
      end
      if (rd_rise) begin
        d.doe = 1'b0;
        if (q.sel) begin
          exec = 1'b1;
          d.sel = 1'b0;
        end
      end
      if (wr_rise && q.sel) begin
        exec = 1'b1;
        ecode = q.d2;
        d.sel = 1'b0;
      end
    end
    // acceptance of a completed command
    if (exec) begin
      if (lcd_port_pkg::is_poll(q.c1, q.c2, q.rw)) begin
        // the poll never sets busy
        d.code = q.code;
      end else if (!q.busy) begin
        // busy commands are dropped, not queued
        d.busy = 1'b1;
        d.cnt = 16'(lcd_port_pkg::EXEC_CYC - 1);
        d.code = ecode;
        // the no-op raises busy but gives no execute pulse
        d.cv = ~lcd_port_pkg::is_nop(q.c1, q.c2, q.rw, ecode);
        if (lcd_port_pkg::is_sf(q.c1, q.c2, q.rw, ecode) && !q.mux) begin
          d.nib = ~ecode[lcd_port_pkg::SF_WIDTH_BIT];
          // the switch strobe pair: its second half lands as a lower nibble
          d.phase = ~q.nib & ~ecode[lcd_port_pkg::SF_WIDTH_BIT];
        end
      end
    end
  end
  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end
  // outputs straight from the state register
  assign port_io.dev_bus_out = q.dout;
  assign port_io.dev_bus_oe = q.doe;
  assign cmd_valid_out = q.cv;
  assign cmd_c1_out = q.c1;
  assign cmd_c2_out = q.c2;
  assign cmd_rw_out = q.rw;
  assign cmd_code_out = q.code;
  assign busy_out = q.busy;
  assign nibble_mode_out = q.nib;
endmodule : lcd_port_device

// *** verilog/lcd_port_host.sv ***
// host end: avalon-mm register slave driving the command port pins
`timescale 1ns/1ps
module lcd_port_host (
  input wire logic clk_in,
  input wire logic rst_n_in,
  lcd_port_if.host_end port_io,
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out
);
  // beat phases, gray along the path except the HOLD to SETUP step
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_SETUP = 2'b01, H_STRB = 2'b11,
                            H_HOLD = 2'b10} hstate_t;
  typedef struct packed {
    hstate_t st; // beat phase
    logic [3:0] div; // phase divider
    logic tick; // one-cycle phase enable
    logic mux; // muxed-bus mode
    logic nib; // nibble mode in force
    logic c1, c2, rw; // job class and direction
    logic [7:0] code; // job code
    logic poll; // busy poll in progress
    logic nib_tx; // beats of this command go as nibbles
    logic beat; // second beat of a pair
    logic [7:0] acc; // assembled read byte
    logic [7:0] rdata; // last read result
    logic [7:0] b1, b2; // data line synchroniser
    logic stb, p1, p2, prw; // pin drive
    logic [7:0] bout; // data drive
    logic boe; // data enable
    logic wait_q; // waitrequest
    logic [31:0] rd_q; // readdata
  } host_state_t;
  host_state_t q, d;
  logic pc1, pc2, prw, last;
  // next state
  always_comb begin
    d = q;
    d.b1 = port_io.host_data_bus;
    d.b2 = q.b1;
    d.tick = (q.div == 4'(lcd_port_pkg::PHASE_CYC - 2));
    d.div = d.tick ? 4'h0 : q.div + 4'h1;
    // pins of the current command: poll or job
    pc1 = q.poll ? 1'b0 : q.c1;
    pc2 = q.poll ? 1'b0 : q.c2;
    prw = q.poll ? 1'b1 : q.rw;
    last = q.mux ? q.beat : (~q.nib_tx | q.beat);
    if (q.tick) begin
      unique case (q.st)
        H_IDLE: ;
        H_SETUP: d.st = H_STRB;
        H_STRB: begin
          d.st = H_HOLD;
          // sample read data at the end of the strobe
          if (q.mux | ~q.nib_tx) d.acc = q.b2;
          else if (!q.beat) d.acc[7:4] = q.b2[7:4];
          else d.acc[3:0] = q.b2[7:4];
        end
        H_HOLD: begin
          d.st = H_SETUP;
          if (!last) d.beat = 1'b1;
          else begin
            d.beat = 1'b0;
            if (q.poll) begin
              // repeat the poll until busy reads zero
              if (!q.acc[lcd_port_pkg::BUSY_BIT]) begin
                d.poll = 1'b0;
                // nibble-select set-function goes out as two strobes
                d.nib_tx = q.nib | (~q.mux & lcd_port_pkg::is_sf(q.c1, q.c2, q.rw, q.code)
                                    & ~q.code[lcd_port_pkg::SF_WIDTH_BIT]);
              end
            end else begin
              d.st = H_IDLE;
              if (q.rw) d.rdata = q.acc;
              // muxed bus never changes width
              if (!q.mux && lcd_port_pkg::is_sf(q.c1, q.c2, q.rw, q.code))
                d.nib = ~q.code[lcd_port_pkg::SF_WIDTH_BIT];
            end
          end
        end
      endcase
    end
    // avalon: drop waitrequest for one cycle per accepted access
    d.wait_q = 1'b1;
    if ((read_in | write_in) & q.wait_q) begin
      if (!(write_in && address_in == lcd_port_pkg::REG_CMD && q.st != H_IDLE)) begin
        d.wait_q = 1'b0;
        unique case (address_in)
          lcd_port_pkg::REG_CMD: d.rd_q = {21'h0, q.c1, q.c2, q.rw, q.code};
          lcd_port_pkg::REG_MODE: d.rd_q = {30'h0, q.nib, q.mux};
          lcd_port_pkg::REG_STAT: d.rd_q = {16'h0, q.rdata, 7'h0, q.st != H_IDLE};
          default: d.rd_q = 32'h0; // unmapped reads zero
        endcase
      end
    end
    // write takes effect on the edge that sees waitrequest low
    if (write_in & ~q.wait_q) begin
      if (address_in == lcd_port_pkg::REG_CMD) begin
        d.c1 = writedata_in[lcd_port_pkg::CMD_C1_BIT];
        d.c2 = writedata_in[lcd_port_pkg::CMD_C2_BIT];
        d.rw = writedata_in[lcd_port_pkg::CMD_RW_BIT];
        d.code = writedata_in[7:0];
        d.st = H_SETUP;
        d.beat = 1'b0;
        d.nib_tx = q.nib;
        // any command but the poll is preceded by polls
        d.poll = ~lcd_port_pkg::is_poll(writedata_in[lcd_port_pkg::CMD_C1_BIT],
                   writedata_in[lcd_port_pkg::CMD_C2_BIT],
                   writedata_in[lcd_port_pkg::CMD_RW_BIT]);
      end else if (address_in == lcd_port_pkg::REG_MODE) begin
        d.mux = writedata_in[lcd_port_pkg::MODE_MUX_BIT];
      end
    end
    // pin drive for the next cycle
    pc1 = d.poll ? 1'b0 : d.c1;
    pc2 = d.poll ? 1'b0 : d.c2;
    prw = d.poll ? 1'b1 : d.rw;
    if (d.mux) begin
      // io cycle: latch pulse with address, then read or write strobe
      d.stb = (d.st == H_STRB) & ~d.beat;
      d.p2 = 1'b1;
      d.p1 = ~((d.st == H_STRB) & d.beat & ~prw);
      d.prw = ~((d.st == H_STRB) & d.beat & prw);
      d.boe = (d.st != H_IDLE) & (~d.beat | ~prw);
      d.bout = d.beat ? d.code : {lcd_port_pkg::IO_ADDR_HI, prw, pc1, pc2};
    end else begin
      // same class and direction for both strobes
      d.stb = (d.st == H_STRB);
      d.p1 = pc1;
      d.p2 = pc2;
      d.prw = prw;
      d.boe = (d.st != H_IDLE) & ~prw;
      if (!d.nib_tx) d.bout = d.poll ? 8'h00 : d.code;
      else d.bout = {d.beat ? d.code[3:0] : d.code[7:4], 4'h0};
    end
    if (d.st == H_IDLE) begin
      d.stb = 1'b0;
      d.p1 = d.mux;
      d.p2 = d.mux;
      d.prw = d.mux;
    end
  end
  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '{st: H_IDLE, wait_q: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end
  assign port_io.execute_strobe = q.stb;
  assign port_io.instr_class_bit1 = q.p1;
  assign port_io.instr_class_bit2 = q.p2;
  assign port_io.read_write_select = q.prw;
  assign port_io.host_bus_out = q.bout;
  assign port_io.host_bus_oe = q.boe;
  assign readdata_out = q.rd_q;
  assign waitrequest_out = q.wait_q;
endmodule : lcd_port_host

// *** verilog/lcd_port_if.sv ***
// pins between the host end and the display controller end
`timescale 1ns/1ps
interface lcd_port_if;
  logic execute_strobe; // port strobe, or address latch in muxed mode
  logic instr_class_bit1; // class bit, or write strobe low in muxed mode
  logic instr_class_bit2; // class bit, or io_memory_select in muxed mode
  logic read_write_select; // direction, or read strobe low in muxed mode
  logic [7:0] host_bus_out; // host drive value
  logic host_bus_oe; // host drives data lines
  logic [7:0] dev_bus_out; // device drive value
  logic dev_bus_oe; // device drives data lines
  logic [7:0] host_data_bus; // resolved line level
  // pull-ups hold idle lines high
  assign host_data_bus = host_bus_oe ? host_bus_out : (dev_bus_oe ? dev_bus_out : 8'hff);
  modport host_end (
    output execute_strobe, instr_class_bit1, instr_class_bit2, read_write_select,
    output host_bus_out, host_bus_oe,
    input host_data_bus
  );
  modport device_end (
    input execute_strobe, instr_class_bit1, instr_class_bit2, read_write_select,
    input host_data_bus,
    output dev_bus_out, dev_bus_oe
  );
endinterface : lcd_port_if

// *** verilog/lcd_port_pkg.sv ***
// constants shared by both ends of the display controller command port
package lcd_port_pkg;
  localparam int CLK_MHZ = 250;
  localparam int AUTOCLEAR_NS = 100000;
  localparam int EXEC_NS = 4000;
  localparam int PHASE_NS = 40;
  // least time in whole cycles, never below one
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : min_cycles
  localparam int AUTOCLEAR_CYC = min_cycles(AUTOCLEAR_NS);
  localparam int EXEC_CYC = min_cycles(EXEC_NS);
  localparam int PHASE_CYC = min_cycles(PHASE_NS);
  // pin vector positions {strobe, class1, class2, direction}
  localparam int PIN_STB = 3;
  localparam int PIN_C1 = 2;
  localparam int PIN_C2 = 1;
  localparam int PIN_RW = 0;
  // status byte and set-function fields
  localparam int BUSY_BIT = 7;
  localparam int NIB_FLAG_BIT = 6;
  localparam logic [7:0] SF_MASK = 8'hc0;
  localparam logic [7:0] SF_MATCH = 8'hc0;
  localparam int SF_WIDTH_BIT = 5;
  // muxed-bus address decode
  localparam logic [4:0] IO_ADDR_HI = 5'h1f;
  localparam int ADDR_RW_BIT = 2;
  localparam int ADDR_C1_BIT = 1;
  localparam int ADDR_C2_BIT = 0;
  // controller registers, byte addresses
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_MODE = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int CMD_C1_BIT = 10;
  localparam int CMD_C2_BIT = 9;
  localparam int CMD_RW_BIT = 8;
  localparam int MODE_MUX_BIT = 0;
  localparam int MODE_NIB_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDATA_LSB = 8;
  // busy poll: class 00 read
  function automatic logic is_poll(input logic c1, input logic c2, input logic rw);
    return rw & ~c1 & ~c2;
  endfunction : is_poll
  // no-op: everything zero
  function automatic logic is_nop(input logic c1, input logic c2, input logic rw,
                                  input logic [7:0] code);
    return ~rw & ~c1 & ~c2 & (code == 8'h00);
  endfunction : is_nop
  // set-function: class 00 write with its opcode bits
  function automatic logic is_sf(input logic c1, input logic c2, input logic rw,
                                 input logic [7:0] code);
    return ~rw & ~c1 & ~c2 & ((code & SF_MASK) == SF_MATCH);
  endfunction : is_sf
endpackage : lcd_port_pkg
